// ===== shared/ext_op_pkg.sv
// Package: constants, opcodes and types of the extended-op decode/execute
package ext_op_pkg;

    // ==================================================================
    // Widths
    // ==================================================================
    localparam int PTR_W = 12; // Indirect-address pointer width
    localparam int PC_W = 21; // Program counter width
    localparam int DATA_W = 8; // Data memory word width
    localparam int LIT6_W = 6; // Pointer literal width
    localparam int OFS_W = 7; // Indexed offset width

    // ==================================================================
    // Opcode fields of the first and second words
    // ==================================================================
    localparam logic [7:0] OPC_ADD_PTR = 8'hE8; // Add literal to pointer
    localparam logic [7:0] OPC_SUB_PTR = 8'hE9; // Subtract from pointer
    localparam logic [7:0] OPC_PUSH_LIT = 8'hEA; // Literal push
    localparam logic [7:0] OPC_MOVE = 8'hEB; // Indexed move, first word
    localparam logic [15:0] OPC_CALL_W = 16'h0014; // Call via W
    localparam logic [3:0] OPC_MOVE_W2 = 4'hF; // Second word prefix

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int SEL_HI = 7; // Pointer select field
    localparam int SEL_LO = 6;
    localparam int MOVE_KIND_BIT = 7; // 0 absolute, 1 indexed dest
    localparam int ABS_HI = 11; // Absolute destination field
    localparam logic [1:0] SEL_FRAME_RET = 2'h3; // Frame op with return
    localparam logic [1:0] FRAME_PTR = 2'h2; // Stack-frame pointer index

    // ==================================================================
    // Reset values
    // ==================================================================
    localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_LITERAL_TO_POINTER,
        OP_ADD_TO_FRAME_POINTER_AND_RETURN,
        OP_SUBTRACT_LITERAL_FROM_POINTER,
        OP_SUBTRACT_FROM_FRAME_POINTER_AND_RETURN,
        OP_CALL_VIA_WORKING_REGISTER,
        OP_INDEXED_TO_ABSOLUTE_MOVE,
        OP_INDEXED_TO_INDEXED_MOVE,
        OP_LITERAL_PUSH
    } ext_op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_FIRST,
        ST_FLUSH,
        ST_MOVE_SECOND
    } seq_state_e;

endpackage

// ===== shared/ext_dec_if.sv
// Interface: decoded fields passed from decoder to executer
`timescale 1ns/10ps
interface ext_dec_if;
    import ext_op_pkg::*;
    ext_op_e op; // Decoded operation of the first word
    logic [1:0] sel; // Pointer select
    logic [LIT6_W-1:0] lit6; // 6-bit literal
    logic [DATA_W-1:0] lit8; // 8-bit push literal
    logic [OFS_W-1:0] ofs; // Source offset of a move

    modport dec (output op, sel, lit6, lit8, ofs);
    modport exe (input op, sel, lit6, lit8, ofs);
endinterface

// ===== logic/ext_op_decoder.sv
// Combinational decoder of the first word of an extended instruction
`timescale 1ns/10ps
module ext_op_decoder (
    input wire logic [15:0] word,
    input wire logic enable,
    ext_dec_if.dec dec
);
    import ext_op_pkg::*;

    // ==================================================================
    // Field split and opcode match
    // ==================================================================
    // Fields are always presented; only op says whether they matter
    always_comb begin
        dec.sel = word[SEL_HI:SEL_LO];
        dec.lit6 = word[LIT6_W-1:0];
        dec.lit8 = word[DATA_W-1:0];
        dec.ofs = word[OFS_W-1:0];
        dec.op = OP_NONE;
        // Disabled: every word falls through to the standard decoder
        if (!enable) begin
            dec.op = OP_NONE;
        end else if (word[15:8] == OPC_ADD_PTR) begin
            if (word[SEL_HI:SEL_LO] == SEL_FRAME_RET) begin
                dec.op = OP_ADD_TO_FRAME_POINTER_AND_RETURN;
            end else begin
                dec.op = OP_ADD_LITERAL_TO_POINTER;
            end
        end else if (word[15:8] == OPC_SUB_PTR) begin
            if (word[SEL_HI:SEL_LO] == SEL_FRAME_RET) begin
                dec.op = OP_SUBTRACT_FROM_FRAME_POINTER_AND_RETURN;
            end else begin
                dec.op = OP_SUBTRACT_LITERAL_FROM_POINTER;
            end
        end else if (word[15:8] == OPC_PUSH_LIT) begin
            dec.op = OP_LITERAL_PUSH;
        end else if (word[15:8] == OPC_MOVE) begin
            if (word[MOVE_KIND_BIT]) begin
                dec.op = OP_INDEXED_TO_INDEXED_MOVE;
            end else begin
                dec.op = OP_INDEXED_TO_ABSOLUTE_MOVE;
            end
        end else if (word == OPC_CALL_W) begin
            dec.op = OP_CALL_VIA_WORKING_REGISTER;
        end
    end
endmodule

// ===== logic/extended_op_decode_execute.sv
// Decode/execute of the optional extended CPU instructions
// Overview of operation
// - Decode add literal to selected pointer, one cycle
// - Field selects pointer 0-2, literal 0..63
// - Add to frame pointer, return, two cycles
// - Decode subtract literal from pointer, one cycle
// - Subtract from frame pointer, return, two cycles
// - Call via working register, two cycles
// - Push literal at frame pointer, then decrement
// - Extensions off until configuration enable bit set
`timescale 1ns/10ps
module extended_op_decode_execute (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic extension_enable_bit,
    input wire logic [ext_op_pkg::PTR_W-1:0] pointer_0,
    input wire logic [ext_op_pkg::PTR_W-1:0] pointer_1,
    input wire logic [ext_op_pkg::PTR_W-1:0] stack_frame_pointer,
    input wire logic [ext_op_pkg::DATA_W-1:0] working_register,
    input wire logic [4:0] pc_latch_upper,
    input wire logic [7:0] pc_latch_high,
    input wire logic [ext_op_pkg::PC_W-1:0] pc_next,
    input wire logic [ext_op_pkg::PC_W-1:0] return_stack_top,
    input wire logic [ext_op_pkg::DATA_W-1:0] mem_rdata,
    output logic ext_hit,
    output logic nop_cycle,
    output logic ptr_we,
    output logic [1:0] ptr_sel,
    output logic [ext_op_pkg::PTR_W-1:0] ptr_wdata,
    output logic pc_load,
    output logic [ext_op_pkg::PC_W-1:0] pc_wdata,
    output logic stack_push,
    output logic stack_pop,
    output logic [ext_op_pkg::PC_W-1:0] stack_push_data,
    output logic mem_re,
    output logic mem_we,
    output logic [ext_op_pkg::PTR_W-1:0] mem_addr,
    output logic [ext_op_pkg::DATA_W-1:0] mem_wdata
);
    import ext_op_pkg::*;

    // ==================================================================
    // Declarations
    // ==================================================================
    ext_dec_if dec_bus (); // Decoded first-word fields
    logic enable_q, enable_d; // Registered configuration enable
    seq_state_e state_q, state_d; // Sequencer state
    logic [PTR_W-1:0] move_base_q, move_base_d; // Frame pointer for word 2
    logic move_kind_q, move_kind_d; // Pending move has indexed destination
    logic ext_hit_q, ext_hit_d; // Word consumed by this block
    logic nop_q, nop_d; // Cycle executes as no-operation
    logic ptr_we_q, ptr_we_d; // Pointer write strobe
    logic [1:0] ptr_sel_q, ptr_sel_d; // Pointer written
    logic [PTR_W-1:0] ptr_wdata_q, ptr_wdata_d; // New pointer value
    logic pc_load_q, pc_load_d; // Program counter load strobe
    logic [PC_W-1:0] pc_wdata_q, pc_wdata_d; // New program counter
    logic push_q, push_d; // Return stack push
    logic pop_q, pop_d; // Return stack pop
    logic [PC_W-1:0] push_data_q, push_data_d; // Return address pushed
    logic mem_re_q, mem_re_d; // Data memory read strobe
    logic mem_we_q, mem_we_d; // Data memory write strobe
    logic [PTR_W-1:0] mem_addr_q, mem_addr_d; // Data memory address
    logic [DATA_W-1:0] mem_wdata_q, mem_wdata_d; // Data memory write data
    logic [PTR_W-1:0] sel_ptr; // Pointer picked by the select field
    logic [PTR_W-1:0] lit_ext; // Literal widened to pointer width

    // ==================================================================
    // Decoder
    // ==================================================================
    ext_op_decoder u_dec (
        .word(instr_word),
        .enable(enable_q),
        .dec(dec_bus.dec)
    );

    // Select the operand pointer; select 3 never reaches this path
    always_comb begin
        lit_ext = {{(PTR_W-LIT6_W){1'b0}}, dec_bus.lit6};
        if (dec_bus.sel == 2'h0) begin
            sel_ptr = pointer_0;
        end else if (dec_bus.sel == 2'h1) begin
            sel_ptr = pointer_1;
        end else begin
            sel_ptr = stack_frame_pointer;
        end
    end

    // ==================================================================
    // Next-state and output computation
    // ==================================================================
    // Status flags are never touched: the block has no flag outputs,
    // so every extended op leaves them as they were
    always_comb begin
        enable_d = extension_enable_bit;
        state_d = state_q;
        move_base_d = move_base_q;
        move_kind_d = move_kind_q;
        ext_hit_d = 1'b0;
        nop_d = 1'b0;
        ptr_we_d = 1'b0;
        ptr_sel_d = ptr_sel_q;
        ptr_wdata_d = ptr_wdata_q;
        pc_load_d = 1'b0;
        pc_wdata_d = pc_wdata_q;
        push_d = 1'b0;
        pop_d = 1'b0;
        push_data_d = push_data_q;
        mem_re_d = 1'b0;
        mem_we_d = 1'b0;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        case (state_q)
            // First word of any instruction
            ST_FIRST: begin
                if (instr_valid) begin
                    ext_hit_d = (dec_bus.op != OP_NONE); // Ours if decoded
                    case (dec_bus.op)
                        OP_ADD_LITERAL_TO_POINTER: begin
                            ptr_we_d = 1'b1;
                            ptr_sel_d = dec_bus.sel;
                            ptr_wdata_d = PTR_W'(sel_ptr + lit_ext);
                        end
                        OP_SUBTRACT_LITERAL_FROM_POINTER: begin
                            ptr_we_d = 1'b1;
                            ptr_sel_d = dec_bus.sel;
                            ptr_wdata_d = PTR_W'(sel_ptr - lit_ext);
                        end
                        OP_ADD_TO_FRAME_POINTER_AND_RETURN: begin
                            ptr_we_d = 1'b1;
                            ptr_sel_d = FRAME_PTR;
                            ptr_wdata_d = PTR_W'(stack_frame_pointer
                                + lit_ext);
                            pc_load_d = 1'b1;
                            pc_wdata_d = return_stack_top;
                            pop_d = 1'b1;
                            state_d = ST_FLUSH;
                        end
                        OP_SUBTRACT_FROM_FRAME_POINTER_AND_RETURN: begin
                            ptr_we_d = 1'b1;
                            ptr_sel_d = FRAME_PTR;
                            ptr_wdata_d = PTR_W'(stack_frame_pointer
                                - lit_ext);
                            pc_load_d = 1'b1;
                            pc_wdata_d = return_stack_top;
                            pop_d = 1'b1;
                            state_d = ST_FLUSH;
                        end
                        OP_CALL_VIA_WORKING_REGISTER: begin
                            // Return address pushed, PC from latches and W
                            push_d = 1'b1;
                            push_data_d = pc_next;
                            pc_load_d = 1'b1;
                            pc_wdata_d = {pc_latch_upper, pc_latch_high,
                                working_register};
                            state_d = ST_FLUSH;
                        end
                        OP_INDEXED_TO_ABSOLUTE_MOVE,
                        OP_INDEXED_TO_INDEXED_MOVE: begin
                            // Fetch the source now; the second word names
                            // the destination while the data returns
                            mem_re_d = 1'b1;
                            mem_addr_d = PTR_W'(stack_frame_pointer
                                + {5'h00, dec_bus.ofs});
                            move_base_d = stack_frame_pointer;
                            move_kind_d = (dec_bus.op
                                == OP_INDEXED_TO_INDEXED_MOVE);
                            state_d = ST_MOVE_SECOND;
                        end
                        OP_LITERAL_PUSH: begin
                            // Store and decrement share one cycle
                            mem_we_d = 1'b1;
                            mem_addr_d = stack_frame_pointer;
                            mem_wdata_d = dec_bus.lit8;
                            ptr_we_d = 1'b1;
                            ptr_sel_d = FRAME_PTR;
                            ptr_wdata_d = PTR_W'(stack_frame_pointer
                                - 12'h001);
                        end
                        default: begin
                            // Standard instruction: ext_hit stays low
                        end
                    endcase
                end
            end
            // Second cycle of return or call: the fetched word is dropped
            ST_FLUSH: begin
                if (instr_valid) begin
                    ext_hit_d = 1'b1;
                    nop_d = 1'b1;
                    state_d = ST_FIRST;
                end
            end
            // Second word of a move: write the source byte to destination
            ST_MOVE_SECOND: begin
                if (instr_valid) begin
                    ext_hit_d = 1'b1;
                    state_d = ST_FIRST;
                    // A bad prefix executes as a plain no-operation
                    if (instr_word[15:12] == OPC_MOVE_W2) begin
                        mem_we_d = 1'b1;
                        mem_wdata_d = mem_rdata;
                        if (move_kind_q) begin
                            mem_addr_d = PTR_W'(move_base_q
                                + {5'h00, instr_word[OFS_W-1:0]});
                        end else begin
                            mem_addr_d = instr_word[ABS_HI:0];
                        end
                    end else begin
                        nop_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = ST_FIRST;
            end
        endcase
    end

    // ==================================================================
    // State registers
    // ==================================================================
    // Enable is cleared by reset, so extensions start inactive
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_q <= 1'b0;
            state_q <= ST_FIRST;
            move_base_q <= PTR_RST;
            move_kind_q <= 1'b0;
            ext_hit_q <= 1'b0;
            nop_q <= 1'b0;
            ptr_we_q <= 1'b0;
            ptr_sel_q <= 2'h0;
            ptr_wdata_q <= PTR_RST;
            pc_load_q <= 1'b0;
            pc_wdata_q <= PC_RST;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            push_data_q <= PC_RST;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= PTR_RST;
            mem_wdata_q <= DATA_RST;
        end else begin
            enable_q <= enable_d;
            state_q <= state_d;
            move_base_q <= move_base_d;
            move_kind_q <= move_kind_d;
            ext_hit_q <= ext_hit_d;
            nop_q <= nop_d;
            ptr_we_q <= ptr_we_d;
            ptr_sel_q <= ptr_sel_d;
            ptr_wdata_q <= ptr_wdata_d;
            pc_load_q <= pc_load_d;
            pc_wdata_q <= pc_wdata_d;
            push_q <= push_d;
            pop_q <= pop_d;
            push_data_q <= push_data_d;
            mem_re_q <= mem_re_d;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // ==================================================================
    // Outputs, straight from flip-flops
    // ==================================================================
    assign ext_hit = ext_hit_q;
    assign nop_cycle = nop_q;
    assign ptr_we = ptr_we_q;
    assign ptr_sel = ptr_sel_q;
    assign ptr_wdata = ptr_wdata_q;
    assign pc_load = pc_load_q;
    assign pc_wdata = pc_wdata_q;
    assign stack_push = push_q;
    assign stack_pop = pop_q;
    assign stack_push_data = push_data_q;
    assign mem_re = mem_re_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
endmodule

// ===== tb/ext_op_checker.sv
// Checker: concurrent assertions on the extended-op decoder ports
`timescale 1ns/10ps
module ext_op_checker
    import ext_op_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] instr_word,
    input wire logic extension_enable_bit,
    input wire logic [ext_op_pkg::PTR_W-1:0] pointer_0,
    input wire logic [ext_op_pkg::PTR_W-1:0] pointer_1,
    input wire logic [ext_op_pkg::PTR_W-1:0] stack_frame_pointer,
    input wire logic [ext_op_pkg::DATA_W-1:0] working_register,
    input wire logic [4:0] pc_latch_upper,
    input wire logic [7:0] pc_latch_high,
    input wire logic [ext_op_pkg::PC_W-1:0] pc_next,
    input wire logic [ext_op_pkg::PC_W-1:0] return_stack_top,
    input wire logic [ext_op_pkg::DATA_W-1:0] mem_rdata,
    input wire logic ext_hit,
    input wire logic ptr_we,
    input wire logic [1:0] ptr_sel,
    input wire logic [ext_op_pkg::PTR_W-1:0] ptr_wdata,
    input wire logic pc_load,
    input wire logic [ext_op_pkg::PC_W-1:0] pc_wdata,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [ext_op_pkg::PC_W-1:0] stack_push_data,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [ext_op_pkg::PTR_W-1:0] mem_addr,
    input wire logic [ext_op_pkg::DATA_W-1:0] mem_wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Helper: pointer picked by the select field of each word
    // ==========================================================
    logic [PTR_W-1:0] sel_ptr_q; // Pointer the last word named
    // Lines up with the output edge; select 3 takes the frame pointer
    always_ff @(posedge clk) begin
        if (instr_word[7:6] == 2'h0) sel_ptr_q <= pointer_0;
        else if (instr_word[7:6] == 2'h1) sel_ptr_q <= pointer_1;
        else sel_ptr_q <= stack_frame_pointer;
    end
    // ==========================================================
    // Assertions
    // ==========================================================
    chk_ptr_arith: assert property (
        ptr_we && $past(instr_word[15:9]) == 7'h74 |-> ptr_wdata ==
        ($past(instr_word[8]) ? sel_ptr_q - PTR_W'($past(instr_word[5:0]))
         : sel_ptr_q + PTR_W'($past(instr_word[5:0]))))
        else $error("pointer sum wrong");
    chk_ptr_select: assert property (
        ptr_we && $past(instr_word[15:9]) == 7'h74 |-> ptr_sel ==
        ($past(instr_word[7:6]) == 2'h3 ? FRAME_PTR : $past(instr_word[7:6])))
        else $error("pointer select wrong");
    chk_return_pc: assert property (
        stack_pop |-> pc_load && pc_wdata == $past(return_stack_top))
        else $error("return target wrong");
    chk_return_nop: assert property (
        stack_pop || stack_push |=> !ptr_we && !mem_we && !pc_load)
        else $error("second cycle not idle");
    chk_call_target: assert property (
        stack_push |-> pc_load && stack_push_data == $past(pc_next) &&
        pc_wdata == {$past(pc_latch_upper), $past(pc_latch_high),
        $past(working_register)})
        else $error("call target wrong");
    chk_push_write: assert property (
        mem_we && $past(instr_word[15:8]) == OPC_PUSH_LIT |->
        mem_addr == $past(stack_frame_pointer) && ptr_we &&
        mem_wdata == $past(instr_word[7:0]) &&
        ptr_wdata == $past(stack_frame_pointer) - 12'h001)
        else $error("literal push wrong");
    chk_move_read: assert property (
        mem_re |-> $past(instr_word[15:8]) == OPC_MOVE && mem_addr ==
        $past(stack_frame_pointer) + PTR_W'($past(instr_word[6:0])))
        else $error("move source wrong");
    chk_move_data: assert property (
        mem_we && !ptr_we |-> mem_wdata == $past(mem_rdata))
        else $error("move data wrong");
    chk_disabled_quiet: assert property (
        !$past(extension_enable_bit) && !$past(extension_enable_bit, 2)
        |-> !ext_hit)
        else $error("decode while disabled");
    cov_return: cover property (stack_pop);
    cov_call: cover property (stack_push);
    cov_move: cover property (mem_re ##[1:4] mem_we);
endmodule
bind extended_op_decode_execute ext_op_checker i_ext_op_checker (
    .clk, .reset_n, .instr_word, .extension_enable_bit, .pointer_0,
    .pointer_1, .stack_frame_pointer, .working_register, .pc_latch_upper,
    .pc_latch_high, .pc_next, .return_stack_top, .mem_rdata, .ext_hit,
    .ptr_we, .ptr_sel, .ptr_wdata, .pc_load, .pc_wdata, .stack_push,
    .stack_pop, .stack_push_data, .mem_re, .mem_we, .mem_addr, .mem_wdata);

// ===== tb/extended_op_decode_execute_bench.sv
// Testbench: random and corner-case runs of the extended-op decoder
`timescale 1ns/10ps
module extended_op_decode_execute_bench;
    import ext_op_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic clk = 1'h0;
    logic reset_n = 1'h0; // Held low for the first 16 cycles
    logic instr_valid = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    logic extension_enable_bit = 1'h1;
    logic [PTR_W-1:0] pointer_0, pointer_1, stack_frame_pointer;
    logic [DATA_W-1:0] working_register, mem_rdata;
    logic [4:0] pc_latch_upper;
    logic [7:0] pc_latch_high;
    logic [PC_W-1:0] pc_next, return_stack_top;
    logic ext_hit, nop_cycle, ptr_we, pc_load, stack_push, stack_pop;
    logic mem_re, mem_we;
    logic [1:0] ptr_sel;
    logic [PTR_W-1:0] ptr_wdata, mem_addr;
    logic [PC_W-1:0] pc_wdata, stack_push_data;
    logic [DATA_W-1:0] mem_wdata;
    int failures = 0;
    int checked = 0;
    logic [31:0] lfsr_q = 32'hC024; // Fixed seed keeps runs repeatable
    always #50 clk = ~clk;
    extended_op_decode_execute i_extended_op_decode_execute (
        .clk, .reset_n, .instr_valid, .instr_word, .extension_enable_bit,
        .pointer_0, .pointer_1, .stack_frame_pointer, .working_register,
        .pc_latch_upper, .pc_latch_high, .pc_next, .return_stack_top,
        .mem_rdata, .ext_hit, .nop_cycle, .ptr_we, .ptr_sel, .ptr_wdata,
        .pc_load, .pc_wdata, .stack_push, .stack_pop, .stack_push_data,
        .mem_re, .mem_we, .mem_addr, .mem_wdata);
    // ==========================================================
    // Helpers: random source, expectations, compare, verdict
    // ==========================================================
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Wraps at 12 bits like the pointer itself
    function automatic logic [11:0] exp_ptr(input logic sub,
            input logic [11:0] p, input logic [11:0] k);
        return sub ? p - k : p + k;
    endfunction
    function automatic logic [11:0] pick(input logic [1:0] sel);
        return sel == 2'h0 ? pointer_0 : sel == 2'h1 ? pointer_1
            : stack_frame_pointer;
    endfunction
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // New random pointers, call pieces and read data at one edge
    task automatic shuffle;
        lfsr_q = lfsr_next(lfsr_next(lfsr_q));
        @(posedge clk);
        pointer_0 <= lfsr_q[11:0];
        pointer_1 <= lfsr_q[27:16];
        stack_frame_pointer <= {lfsr_q[3:0], lfsr_q[31:24]};
        working_register <= lfsr_q[19:12];
        pc_latch_upper <= lfsr_q[28:24];
        pc_latch_high <= lfsr_q[15:8];
        pc_next <= lfsr_q[20:0];
        return_stack_top <= lfsr_q[30:10];
        mem_rdata <= lfsr_q[7:0];
        lfsr_q = lfsr_next(lfsr_next(lfsr_q));
    endtask
    // One word driven at the next edge and taken at the one after; outputs settled on return
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        instr_valid <= 1'h1;
        instr_word <= w;
        @(posedge clk);
        instr_valid <= 1'h0;
        #1;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [5:0] k;
        logic [1:0] sel;
        repeat (16) @(posedge clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge clk);
        // Pointer add/subtract, literal limits first, then random
        for (int i = 0; i < 24; i++) begin
            shuffle();
            sel = 2'(i % 3);
            k = i < 6 ? (i < 3 ? 6'h3F : 6'h00) : lfsr_q[5:0];
            send({7'h74, i[0], sel, k});
            chk_val(ptr_we, 1'h1);
            chk_val(ptr_sel, sel);
            chk_val(ptr_wdata, exp_ptr(i[0], pick(sel), 12'(k)));
        end
        $display("pointer test done");
        // Frame pointer update with return, then the idle cycle
        for (int i = 0; i < 2; i++) begin
            shuffle();
            send({7'h74, i[0], 2'h3, lfsr_q[5:0]});
            chk_val(ptr_sel, FRAME_PTR);
            chk_val(ptr_wdata, exp_ptr(i[0], stack_frame_pointer,
                12'(lfsr_q[5:0])));
            chk_val({stack_pop, pc_load, pc_wdata},
                {2'h3, return_stack_top});
            send(lfsr_q[31:16]);
            chk_val({ext_hit, nop_cycle, ptr_we}, 3'h6);
        end
        $display("return test done");
        // Call through the working register
        shuffle();
        send(OPC_CALL_W);
        chk_val({stack_push, stack_push_data}, {1'h1, pc_next});
        chk_val(pc_wdata, {pc_latch_upper, pc_latch_high,
            working_register});
        send(lfsr_q[15:0]);
        chk_val({nop_cycle, stack_push, pc_load}, 3'h4);
        $display("call test done");
        // Literal push at the frame pointer
        shuffle();
        send({OPC_PUSH_LIT, lfsr_q[7:0]});
        chk_val({mem_we, mem_addr, mem_wdata},
            {1'h1, stack_frame_pointer, lfsr_q[7:0]});
        chk_val({ptr_we, ptr_sel, ptr_wdata}, {1'h1, FRAME_PTR,
            12'(stack_frame_pointer - 12'h001)});
        $display("push test done");
        // Both move forms, then a second word without the prefix
        for (int i = 0; i < 3; i++) begin
            shuffle();
            send({OPC_MOVE, i[0], lfsr_q[6:0]});
            chk_val({mem_re, mem_addr}, {1'h1, stack_frame_pointer
                + 12'(lfsr_q[6:0])});
            send({i < 2 ? OPC_MOVE_W2 : 4'h7, lfsr_q[23:12]});
            if (i < 2) chk_val({mem_we, mem_addr, mem_wdata}, {1'h1,
                i[0] ? stack_frame_pointer + 12'(lfsr_q[18:12])
                : lfsr_q[23:12], mem_rdata});
            else chk_val({mem_we, nop_cycle}, 2'h1);
        end
        $display("move test done");
        // Enable bit cleared: the same words must be ignored
        @(posedge clk);
        extension_enable_bit <= 1'h0;
        repeat (3) @(posedge clk);
        send({OPC_ADD_PTR, 8'h05});
        chk_val({ext_hit, ptr_we}, 2'h0);
        send(OPC_CALL_W);
        chk_val({ext_hit, stack_push}, 2'h0);
        $display("disable test done");
        print_verdict();
    end
    // Whole run is about 130 cycles; this bound cuts a hang
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
